// ==== rtl/lscr_pkg.sv ====
// Shared constants and carrier types of the LIN status, colour and
// LED-control read-back block.
// Assumes a byte-level LIN protocol layer outside that marks identifiers.
package lscr_pkg;

	// Frame identifiers, full byte as carried on the link
	localparam logic [7:0] REQ_ID         = 8'h20;
	localparam logic [7:0] RESP_STATUS_ID = 8'h11;
	localparam logic [7:0] RESP_COLOR_ID  = 8'h92;
	localparam logic [7:0] RESP_CTRL_ID   = 8'h50;

	localparam logic [1:0] ADDR_PREFIX  = 2'h3;
	localparam logic [7:0] FILL_BYTE    = 8'hff;
	localparam logic [3:0] STATUS_LEN   = 4'h2;
	localparam logic [3:0] COLOR_LEN    = 4'h8;
	localparam logic [3:0] CTRL_LEN     = 4'h2;
	localparam logic [3:0] REQ_DATA_LEN = 4'h2;
	localparam logic [3:0] HIGH_NIBBLE  = 4'hf;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_EVENT = 8'h04;
	localparam logic [7:0] OFS_MASK  = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;

	// Control register fields
	localparam int         CTRL_ADDR_LSB   = 0;
	localparam int         CTRL_CMDOFF_BIT = 8;
	localparam logic [5:0] CTRL_ADDR_RST   = 6'h00;
	localparam logic       CTRL_CMDOFF_RST = 1'b0;

	// Event register bits
	localparam int         EV_W        = 4;
	localparam int         EV_REQ_BIT  = 0;
	localparam int         EV_RESP_BIT = 1;
	localparam int         EV_CKS_BIT  = 2;
	localparam int         EV_IGN_BIT  = 3;
	localparam logic [3:0] EV_RST      = 4'h0;
	localparam logic [3:0] MASK_RST    = 4'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic       valid;
		logic       is_id;
		logic [7:0] data;
	} lscr_rx_t;

	typedef struct packed {
		logic        overflow;
		logic [10:0] value;
	} lscr_mod_t;

	typedef struct packed {
		logic       enable;
		logic       slope;
		logic [5:0] time_val;
	} lscr_fade_t;

	typedef struct packed {
		logic cal_en;
		logic modulation_frequency_select;
		logic leds_on;
		logic thermal_control_enable;
		logic led3_en;
		logic led2_en;
		logic led1_en;
	} lscr_ledctl_t;

	typedef struct packed {
		logic       thermal_shutdown_flag;
		logic       thermal_warning_flag;
		logic       undervoltage_event;
		logic       retry_active;
		logic [2:0] led3_error_code;
		logic [2:0] led2_error_code;
		logic [2:0] led1_error_code;
	} lscr_err_t;

endpackage

// ==== rtl/lscr_checksum.sv ====
// Classic LIN checksum accumulator: eight-bit sum with end-around carry.
// Assumes the caller inverts the sum to form or check the checksum byte.
`timescale 1ns/1ps
module lscr_checksum (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       clear,
	input  wire logic       add,
	input  wire logic [7:0] byte_in,
	output      logic [7:0] sum
);

	logic [7:0] base;
	logic [8:0] raw;
	logic [7:0] sum_next;

	always_comb begin
		base     = clear ? 8'h00 : sum;
		raw      = {1'b0, base} + {1'b0, byte_in};
		// Carry folds back in; cannot overflow a second time
		sum_next = add ? (raw[7:0] + {7'h00, raw[8]}) : base;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sum <= 8'h00;
		end else begin
			sum <= sum_next;
		end
	end

endmodule

// ==== rtl/lscr_readback.sv ====
// LIN read-back command handler with AHB-Lite register slave.
// Assumes a LIN byte layer that delivers received bytes with an identifier
// mark and takes transmitted bytes by a valid/ready handshake.
//
// Operation
// - A request frame carries 11 plus the node address, then all ones.
// - Serving a status read never clears error flags; only full status does.
// - The status answer is the echoed address byte and the status byte.
// - Status byte is shutdown, warning, undervoltage, retry, LED3..1, LIN.
// - The LIN error bit is the OR of all LIN error indications.
// - Each LED error bit is one when its three-bit error code is non-zero.
// - The retry bit is one while error recovery is in progress.
// - Undervoltage is sticky from the event until a full status command.
// - Colour read-back returns the corrected modulation registers.
// - LED1 and LED2 give low byte then ones, overflow and bits 10 to 8.
// - LED3's upper byte carries the intensity in its top nibble.
// - Colour answer has eight bytes, the last one holding the fade setup.
// - The control answer is the address byte and the LED control byte.
// - Every frame ends in a classic checksum over its data bytes.
// - With commands disabled every read-back request is ignored.
`timescale 1ns/1ps
module lscr_readback
	import lscr_pkg::*;
#(
	parameter int LIN_ERR_W = 4,
	parameter int BUF_DEPTH = 8
) (
	input  wire logic                 clock,
	input  wire logic                 rst_b,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output      logic [31:0]          hrdata,
	output      logic                 hreadyout,
	output      logic                 hresp,
	output      logic                 irq,
	input  wire lscr_rx_t             lin_rx,
	input  wire logic                 tx_ready,
	output      logic                 tx_valid,
	output      logic [7:0]           tx_byte,
	input  wire lscr_err_t            err_in,
	input  wire logic [LIN_ERR_W-1:0] lin_errors,
	input  wire logic                 full_status_clr,
	input  wire lscr_mod_t            led1_mod,
	input  wire lscr_mod_t            led2_mod,
	input  wire lscr_mod_t            led3_mod,
	input  wire logic [3:0]           intensity,
	input  wire lscr_fade_t           fade,
	input  wire lscr_ledctl_t         led_ctrl
);

	generate
		if (BUF_DEPTH != 8 || LIN_ERR_W < 1) begin : g_bad_param
			$error("lscr_readback: BUF_DEPTH must be 8, LIN_ERR_W >= 1");
		end
	endgenerate

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_REQ  = 4'b0010,
		S_SEND = 4'b0100,
		S_CKS  = 4'b1000
	} lscr_state_t;

	function automatic logic [7:0] addr_byte(input logic [5:0] a);
		return {ADDR_PREFIX, a};
	endfunction

	function automatic logic led_err(input logic [2:0] code);
		return code != 3'h0;
	endfunction

	function automatic logic [7:0] mod_high(input logic [3:0] top,
	                                        input lscr_mod_t m);
		return {top, m.overflow, m.value[10:8]};
	endfunction

	function automatic logic is_resp_id(input logic [7:0] id);
		return id == RESP_STATUS_ID || id == RESP_COLOR_ID ||
		       id == RESP_CTRL_ID;
	endfunction

	// Software-visible state
	logic [5:0]      node_addr_reg;
	logic            cmd_disable_reg;
	logic [EV_W-1:0] ev_reg;
	logic [EV_W-1:0] mask_reg;
	logic [EV_W-1:0] ev_set;
	logic            ev_clr;
	logic            uv_reg;

	// AHB state
	logic            wr_pend_reg;
	logic [7:0]      wr_addr_reg;
	logic            take;
	logic [31:0]     rd_value;

	// Frame handler state
	lscr_state_t     state_reg;
	logic [3:0]      cnt_reg;
	logic [3:0]      len_reg;
	logic            addr_ok_reg;
	logic            fill_ok_reg;
	logic            armed_reg;
	logic [7:0]      buf_reg [BUF_DEPTH];
	logic [7:0]      resp [BUF_DEPTH];
	logic [3:0]      resp_len;
	logic [7:0]      status_byte;
	logic [7:0]      ctrl_byte;
	logic [3:0]      cnt_inc;

	logic            id_seen;
	logic            data_seen;
	logic            start_send;
	logic            cks_ok;
	logic            tx_accept;
	logic            tx_load;
	logic [7:0]      tx_load_byte;
	logic [7:0]      rx_sum;
	logic [7:0]      tx_sum;

	assign id_seen   = lin_rx.valid & lin_rx.is_id;
	assign data_seen = lin_rx.valid & ~lin_rx.is_id;
	assign tx_accept = tx_valid & tx_ready;
	assign cnt_inc   = cnt_reg + 4'h1;
	assign cks_ok    = lin_rx.data == ~rx_sum;
	assign start_send = state_reg == S_IDLE && id_seen && !cmd_disable_reg &&
	                    armed_reg && is_resp_id(lin_rx.data);

	// Undervoltage holds until the full status command clears it; an event
	// in the clearing cycle wins so it is never lost
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			uv_reg <= 1'b0;
		end else begin
			uv_reg <= (uv_reg & ~full_status_clr) |
			          err_in.undervoltage_event;
		end
	end

	always_comb begin
		status_byte = {err_in.thermal_shutdown_flag,
		               err_in.thermal_warning_flag,
		               uv_reg,
		               err_in.retry_active,
		               led_err(err_in.led3_error_code),
		               led_err(err_in.led2_error_code),
		               led_err(err_in.led1_error_code),
		               |lin_errors};
		ctrl_byte = {led_ctrl.cal_en, led_ctrl.modulation_frequency_select,
		             led_ctrl.leds_on, led_ctrl.thermal_control_enable,
		             led_ctrl.led3_en, led_ctrl.led2_en, led_ctrl.led1_en,
		             1'b1};
	end

	// Answer contents by response identifier; the modulation inputs are
	// the live post-calibration registers, not the written colours
	always_comb begin
		for (int i = 0; i < BUF_DEPTH; i++) begin
			resp[i] = FILL_BYTE;
		end
		resp[0]  = addr_byte(node_addr_reg);
		resp_len = STATUS_LEN;
		case (lin_rx.data)
			RESP_STATUS_ID: begin
				resp[1]  = status_byte;
				resp_len = STATUS_LEN;
			end
			RESP_COLOR_ID: begin
				resp[1]  = led1_mod.value[7:0];
				resp[2]  = mod_high(HIGH_NIBBLE, led1_mod);
				resp[3]  = led2_mod.value[7:0];
				resp[4]  = mod_high(HIGH_NIBBLE, led2_mod);
				resp[5]  = led3_mod.value[7:0];
				resp[6]  = mod_high(intensity, led3_mod);
				resp[7]  = {fade.enable, fade.slope, fade.time_val};
				resp_len = COLOR_LEN;
			end
			RESP_CTRL_ID: begin
				resp[1]  = ctrl_byte;
				resp_len = CTRL_LEN;
			end
			default: begin
				resp_len = STATUS_LEN;
			end
		endcase
	end

	// Next byte for the outgoing checksum
	always_comb begin
		tx_load      = 1'b0;
		tx_load_byte = resp[0];
		if (start_send) begin
			tx_load = 1'b1;
		end else if (state_reg == S_SEND && tx_accept && cnt_inc < len_reg) begin
			tx_load      = 1'b1;
			tx_load_byte = buf_reg[cnt_inc[2:0]];
		end
	end

	lscr_checksum u_rx_cks (
		.clock   (clock),
		.rst_b   (rst_b),
		.clear   (id_seen),
		.add     (state_reg == S_REQ && data_seen && cnt_reg < REQ_DATA_LEN),
		.byte_in (lin_rx.data),
		.sum     (rx_sum)
	);

	lscr_checksum u_tx_cks (
		.clock   (clock),
		.rst_b   (rst_b),
		.clear   (start_send),
		.add     (tx_load),
		.byte_in (tx_load_byte),
		.sum     (tx_sum)
	);

	// Frame sequencing: a request arms the node, a response header fires it
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= S_IDLE;
			cnt_reg     <= 4'h0;
			len_reg     <= STATUS_LEN;
			addr_ok_reg <= 1'b0;
			fill_ok_reg <= 1'b0;
			armed_reg   <= 1'b0;
			tx_valid    <= 1'b0;
			tx_byte     <= 8'h00;
			for (int i = 0; i < BUF_DEPTH; i++) begin
				buf_reg[i] <= 8'h00;
			end
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (id_seen && cmd_disable_reg) begin
						armed_reg <= 1'b0;
					end else if (id_seen && lin_rx.data == REQ_ID) begin
						state_reg   <= S_REQ;
						cnt_reg     <= 4'h0;
						armed_reg   <= 1'b0;
						addr_ok_reg <= 1'b0;
						fill_ok_reg <= 1'b0;
					end else if (start_send) begin
						state_reg <= S_SEND;
						armed_reg <= 1'b0;
						cnt_reg   <= 4'h0;
						len_reg   <= resp_len;
						tx_valid  <= 1'b1;
						tx_byte   <= resp[0];
						for (int i = 0; i < BUF_DEPTH; i++) begin
							buf_reg[i] <= resp[i];
						end
					end
				end
				S_REQ: begin
					if (id_seen) begin
						state_reg <= S_IDLE;
					end else if (data_seen) begin
						cnt_reg <= cnt_inc;
						if (cnt_reg == 4'h0) begin
							addr_ok_reg <= lin_rx.data ==
							               addr_byte(node_addr_reg);
						end else if (cnt_reg == 4'h1) begin
							fill_ok_reg <= lin_rx.data == FILL_BYTE;
						end else begin
							state_reg <= S_IDLE;
							armed_reg <= cks_ok && addr_ok_reg &&
							             fill_ok_reg;
						end
					end
				end
				S_SEND: begin
					// A new header aborts an answer the master gave up on
					if (id_seen) begin
						state_reg <= S_IDLE;
						tx_valid  <= 1'b0;
					end else if (tx_accept) begin
						cnt_reg <= cnt_inc;
						if (cnt_inc < len_reg) begin
							tx_byte <= buf_reg[cnt_inc[2:0]];
						end else begin
							state_reg <= S_CKS;
							tx_byte   <= ~tx_sum;
						end
					end
				end
				S_CKS: begin
					if (id_seen || tx_accept) begin
						state_reg <= S_IDLE;
						tx_valid  <= 1'b0;
					end
				end
				default: begin
					state_reg <= S_IDLE;
					tx_valid  <= 1'b0;
				end
			endcase
		end
	end

	// Block events for the interrupt
	always_comb begin
		ev_set = '0;
		if (id_seen && cmd_disable_reg &&
		    (lin_rx.data == REQ_ID || is_resp_id(lin_rx.data))) begin
			ev_set[EV_IGN_BIT] = 1'b1;
		end
		if (state_reg == S_REQ && data_seen && cnt_reg == REQ_DATA_LEN) begin
			ev_set[EV_CKS_BIT] = ~cks_ok;
			ev_set[EV_REQ_BIT] = cks_ok & addr_ok_reg & fill_ok_reg;
		end
		if (state_reg == S_CKS && tx_accept) begin
			ev_set[EV_RESP_BIT] = 1'b1;
		end
	end

	// AHB-Lite slave, zero wait states: read data is latched at the address
	// phase so it stands during the whole data phase
	assign take = hsel & htrans[1] & hready;

	always_comb begin
		rd_value = 32'h0000_0000;
		case (haddr[7:0])
			OFS_CTRL: begin
				rd_value[CTRL_ADDR_LSB +: 6]   = node_addr_reg;
				rd_value[CTRL_CMDOFF_BIT]      = cmd_disable_reg;
			end
			OFS_EVENT: rd_value[EV_W-1:0] = ev_reg;
			OFS_MASK:  rd_value[EV_W-1:0] = mask_reg;
			OFS_FLAGS: rd_value[7:0]      = status_byte;
			default:   rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hrdata      <= 32'h0000_0000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= take & hwrite & (hsize == HSIZE_WORD);
			if (take) begin
				wr_addr_reg <= haddr[7:0];
			end
			if (take && !hwrite) begin
				hrdata <= rd_value;
			end
		end
	end

	assign ev_clr = take && !hwrite && haddr[7:0] == OFS_EVENT;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			node_addr_reg   <= CTRL_ADDR_RST;
			cmd_disable_reg <= CTRL_CMDOFF_RST;
			mask_reg        <= MASK_RST;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				OFS_CTRL: begin
					node_addr_reg   <= hwdata[CTRL_ADDR_LSB +: 6];
					cmd_disable_reg <= hwdata[CTRL_CMDOFF_BIT];
				end
				OFS_MASK: mask_reg <= hwdata[EV_W-1:0];
				default:  mask_reg <= mask_reg;
			endcase
		end
	end

	// Read clears; an event landing in the same cycle survives
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ev_reg <= EV_RST;
			irq    <= 1'b0;
		end else begin
			ev_reg <= (ev_clr ? '0 : ev_reg) | ev_set;
			irq    <= |(ev_reg & mask_reg);
		end
	end

endmodule

// ==== test/lscr_readback_checker.sv ====
// Concurrent checks on the read-back block's ports.
// Assumes byte checks run only where tx_ready is high for each byte.
`timescale 1ns/1ps
module lscr_readback_checker
	import lscr_pkg::*;
#(
	parameter int LIN_ERR_W = 4
) (
	input wire logic                 clock,
	input wire logic                 rst_b,
	input wire logic [31:0]          hrdata,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	input wire logic                 irq,
	input wire lscr_rx_t             lin_rx,
	input wire logic                 tx_ready,
	input wire logic                 tx_valid,
	input wire logic [7:0]           tx_byte,
	input wire lscr_err_t            err_in,
	input wire logic [LIN_ERR_W-1:0] lin_errors,
	input wire logic [3:0]           intensity,
	input wire lscr_fade_t           fade,
	input wire lscr_ledctl_t         led_ctrl
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence hdr(logic [7:0] id);
		lin_rx.valid && lin_rx.is_id && lin_rx.data == id;
	endsequence
	sequence sent;
		tx_valid && tx_ready;
	endsequence
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	reset_idle_a: assert property ($rose(rst_b) |-> !tx_valid && !irq
		&& hrdata == 32'h0) else $error("outputs busy after reset");
	// A new identifier may abort a stalled byte, so it is left out here
	tx_hold_a: assert property (tx_valid && !tx_ready &&
		!(lin_rx.valid && lin_rx.is_id) |=>
		tx_valid && $stable(tx_byte)) else $error("byte not held");
	id_abort_a: assert property (tx_valid && lin_rx.valid && lin_rx.is_id
		|=> !tx_valid) else $error("send not aborted by identifier");
	echo_addr_a: assert property (
		lin_rx.valid && lin_rx.is_id ##1 $rose(tx_valid) |->
		tx_byte[7:6] == ADDR_PREFIX) else $error("address byte wrong");
	status_byte_a: assert property (
		hdr(RESP_STATUS_ID) ##1 sent |=> tx_byte[7:6] ==
		{err_in.thermal_shutdown_flag, err_in.thermal_warning_flag}
		&& tx_byte[4:0] == {err_in.retry_active,
		|err_in.led3_error_code, |err_in.led2_error_code,
		|err_in.led1_error_code, |lin_errors})
		else $error("status byte wrong");
	colour_fill_a: assert property (
		hdr(RESP_COLOR_ID) ##1 sent [*2] |=> tx_byte[7:4] == HIGH_NIBBLE)
		else $error("colour upper nibble wrong");
	colour_inten_a: assert property (
		hdr(RESP_COLOR_ID) ##1 sent [*6] |=> tx_byte[7:4] == intensity)
		else $error("intensity nibble wrong");
	fade_byte_a: assert property (
		hdr(RESP_COLOR_ID) ##1 sent [*7] |=> tx_byte == fade)
		else $error("fade byte wrong");
	ctrl_byte_a: assert property (
		hdr(RESP_CTRL_ID) ##1 sent |=> tx_byte == {led_ctrl, 1'b1})
		else $error("control byte wrong");
endmodule
bind lscr_readback lscr_readback_checker #(.LIN_ERR_W(LIN_ERR_W)) u_chk (
	.clock, .rst_b, .hrdata, .hreadyout, .hresp, .irq, .lin_rx, .tx_ready,
	.tx_valid, .tx_byte, .err_in, .lin_errors, .intensity, .fade,
	.led_ctrl);

// ==== test/lscr_lin_master.sv ====
// Behavioural LIN master: sends request frames and headers, takes bytes.
// Assumes the byte layer marks identifiers; slow mode stalls every other cycle.
`timescale 1ns/1ps
module lscr_lin_master
	import lscr_pkg::*;
(
	input  wire logic       clock,
	output      lscr_rx_t   lin_rx,
	output      logic       tx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte
);
	logic       slow;
	logic [7:0] got[$];
	initial begin
		lin_rx = '0;
		tx_ready = 1'b0;
		slow = 1'b0;
	end
	always @(posedge clock) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
	function automatic logic [7:0] cks(input logic [7:0] b[$]);
		logic [8:0] s;
		s = '0;
		foreach (b[i]) begin
			s = s + b[i];
			if (s[8])
				s = s - 9'h0ff;
		end
		return ~s[7:0];
	endfunction
	// Idle data shows the inverse so a stale byte is never mistaken
	task automatic put(input logic id, input logic [7:0] d);
		@(posedge clock);
		lin_rx <= '{1'b1, id, d};
		@(posedge clock);
		lin_rx <= '{1'b0, 1'b0, ~d};
	endtask
	task automatic request(input logic [5:0] a, input logic [7:0] d2,
		input logic bad);
		logic [7:0] d1;
		logic [7:0] d[$];
		d1 = {ADDR_PREFIX, a};
		d = {d1, d2};
		put(1'b1, REQ_ID);
		put(1'b0, d1);
		put(1'b0, d2);
		put(1'b0, cks(d) ^ {7'h0, bad});
	endtask
endmodule

// ==== test/tb.sv ====
// Testbench of the read-back block: registers, status rows, colour,
// control, sticky undervoltage, refusals and the interrupt.
// Assumes the master model in slow mode stalls but never drops a byte.
`timescale 1ns/1ps
module tb;
	import lscr_pkg::*;
	typedef struct packed {
		lscr_err_t  e;
		logic [3:0] l;
		logic [7:0] s;
	} lscr_row_t;
	localparam logic [5:0] ADDR = 6'h15;
	localparam logic [7:0] AB = {ADDR_PREFIX, ADDR};
	// Error word is 13 bits: tsd, tw, uv event, retry, led3, led2, led1 codes
	lscr_row_t    rows[4] = '{'{13'h0000, 4'h0, 8'h00},
		'{13'h1008, 4'h0, 8'h84}, '{13'h0a01, 4'h8, 8'h53},
		'{13'h0080, 4'h1, 8'h09}};
	logic         clock = 1'b0;
	logic         rst_b = 1'b0;
	logic         hsel = 1'b0;
	logic         hwrite = 1'b0;
	logic         full_clr = 1'b0;
	logic [31:0]  haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]   htrans = '0;
	logic [2:0]   hsize = '0;
	logic         hreadyout, hresp, irq, tx_valid, tx_ready;
	logic [7:0]   tx_byte;
	lscr_rx_t     lin_rx;
	lscr_err_t    err = '0;
	logic [3:0]   lin_err = '0, inten = 4'ha;
	lscr_mod_t    m1 = {1'b1, 11'h5a3}, m2 = {1'b0, 11'h0ff};
	lscr_mod_t    m3 = {1'b1, 11'h700};
	lscr_fade_t   fade = 8'hab;
	lscr_ledctl_t ctl = 7'h56;
	logic [7:0]   q[$];
	int           miscompares = 0, n_compared = 0;
	lscr_readback DUT (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.irq, .lin_rx, .tx_ready, .tx_valid, .tx_byte, .err_in(err),
		.lin_errors(lin_err), .full_status_clr(full_clr), .led1_mod(m1),
		.led2_mod(m2), .led3_mod(m3), .intensity(inten), .fade,
		.led_ctrl(ctl));
	lscr_lin_master m (.clock, .lin_rx, .tx_ready, .tx_valid, .tx_byte);
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic resp(input logic [7:0] hid, input int n);
		int k;
		m.got.delete();
		m.put(1'b1, hid);
		for (k = 0; k < 300 && m.got.size() < n; k++)
			@(posedge clock);
		if (k == 300) begin
			miscompares++;
			end_of_test();
		end
		repeat (6) @(posedge clock);
	endtask
	task automatic chk_frame(input logic [7:0] e[$]);
		e.push_back(m.cks(e));
		chk("frame_len", e.size(), m.got.size());
		foreach (e[i]) chk("frame_byte", e[i], m.got[i]);
	endtask
	task automatic status(input logic [7:0] s);
		m.request(ADDR, FILL_BYTE, 1'b0);
		resp(RESP_STATUS_ID, 3);
		q = {AB, s};
		chk_frame(q);
	endtask
	task automatic refuse(input logic [5:0] a, input logic [7:0] d2,
		input logic bad);
		m.request(a, d2, bad);
		resp(RESP_STATUS_ID, 0);
		chk("silent", 0, m.got.size());
	endtask
	initial begin
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		ahb(1'b1, 8'h10, '1);
		for (int i = 0; i < 5; i++) begin
			ahb(1'b0, 8'(i * 4), '0);
			chk("reset_reg", 32'h0, rd);
		end
		ahb(1'b1, OFS_CTRL, {26'h0, ADDR});
		ahb(1'b0, OFS_CTRL, '0);
		chk("ctrl", {26'h0, ADDR}, rd);
		$display("registers done");
		foreach (rows[i]) begin
			err <= rows[i].e;
			lin_err <= rows[i].l;
			m.slow <= (i == 3);
			status(rows[i].s);
		end
		chk("irq_masked", 0, irq);
		$display("status rows done");
		m.slow <= 1'b0;
		// Last row left a LIN error standing; only undervoltage may show
		lin_err <= '0;
		err <= 13'h0400;
		@(posedge clock);
		err <= '0;
		repeat (2) status(8'h20);
		ahb(1'b0, OFS_FLAGS, '0);
		chk("flags", 32'h20, rd);
		full_clr <= 1'b1;
		@(posedge clock);
		full_clr <= 1'b0;
		status(8'h00);
		$display("undervoltage done");
		m.request(ADDR, FILL_BYTE, 1'b0);
		resp(RESP_COLOR_ID, 9);
		q = {AB, 8'ha3, 8'hfd, 8'hff, 8'hf0, 8'h00, 8'haf, 8'hab};
		chk_frame(q);
		m.slow <= 1'b1;
		m.request(ADDR, FILL_BYTE, 1'b0);
		resp(RESP_CTRL_ID, 3);
		q = {AB, 8'had};
		chk_frame(q);
		m.request(ADDR, FILL_BYTE, 1'b0);
		m.got.delete();
		m.put(1'b1, RESP_CTRL_ID);
		m.put(1'b1, REQ_ID);
		repeat (10) @(posedge clock);
		chk("abort_short", 1, m.got.size() < 3);
		chk("abort_idle", 0, tx_valid);
		$display("colour and control done");
		m.slow <= 1'b0;
		ahb(1'b0, OFS_EVENT, '0);
		ahb(1'b1, OFS_MASK, 32'h2);
		status(8'h00);
		chk("irq_set", 1, irq);
		ahb(1'b0, OFS_EVENT, '0);
		chk("event", 32'h3, rd);
		repeat (2) @(posedge clock);
		chk("irq_clear", 0, irq);
		refuse(ADDR ^ 6'h1, FILL_BYTE, 1'b0);
		refuse(ADDR, 8'hfe, 1'b0);
		refuse(ADDR, FILL_BYTE, 1'b1);
		ahb(1'b0, OFS_EVENT, '0);
		chk("event_cks", 1, rd[EV_CKS_BIT]);
		ahb(1'b1, OFS_CTRL, {23'h0, 1'b1, 2'h0, ADDR});
		refuse(ADDR, FILL_BYTE, 1'b0);
		ahb(1'b0, OFS_EVENT, '0);
		chk("event_ign", 1, rd[EV_IGN_BIT]);
		$display("refusals done");
		// Reset in mid-run must restore the power-on register state
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		chk("reset_irq", 0, irq);
		chk("reset_tx", 0, tx_valid);
		ahb(1'b0, OFS_CTRL, '0);
		chk("reset_ctrl", 32'h0, rd);
		ahb(1'b0, OFS_MASK, '0);
		chk("reset_mask", 32'h0, rd);
		$display("mid-run reset done");
		end_of_test();
	end
endmodule
